//--- verilog/alc_cmd_port.sv
// adapter side of the parallel link command port with receive lists and indirect registers
`timescale 1ns/10ps
`include "alc_map.svh"

////////////////////////////////////////////////////////////////////////////////
// small fifo with flush; one used for each list
module alc_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   // control
   input  wire logic         flush,
   input  wire logic         push,
   input  wire logic [W-1:0] push_data,
   input  wire logic         pop,
   // state
   output logic [W-1:0]      head,
   output logic              empty,
   output logic              full
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] rd_q, wr_q;
   logic [AW:0]   cnt_q;
   logic          do_push, do_pop;
   if (D < 2 || (1 << AW) != D) begin : g_bad_depth
      $error("fifo depth must be a power of two");
   end

   assign empty   = (cnt_q == '0);
   assign full    = (cnt_q == (AW+1)'(D));
   assign head    = mem[rd_q];
   assign do_push = push && !full;
   assign do_pop  = pop && !empty;

   // storage; a push into a full list is dropped
   always_ff @(posedge clk_sys) begin
      if (do_push) mem[wr_q] <= push_data;
   end

   // pointers and fill count
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_q  <= '0;
         wr_q  <= '0;
         cnt_q <= '0;
      end else if (flush) begin
         rd_q  <= '0;
         wr_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (do_push) wr_q <= wr_q + AW'(1);
         if (do_pop)  rd_q <= rd_q + AW'(1);
         cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
module alc_cmd_port #(
   parameter int          RX_AW     = 14,
   parameter int          BASE_W    = 8,
   parameter int          TX_AW     = 11,
   parameter int          LIST_D    = 16,
   parameter logic [47:0] ROM_VALUE = 48'h0123456789AB  // arbitrary factory address
) (
   // clock and reset
   input  wire logic                clk_sys,
   input  wire logic                rstn,
   // port-side pins
   input  wire logic                port_clk,
   input  wire logic                port_init,
   input  wire alc_pkg::alc_pins_t  port_pins,
   output logic [7:0]               data_out,
   output logic                     data_oe,
   output logic                     rx_data_parity,
   output logic                     frame_last_byte,
   output logic                     rx_attention,
   output logic [7:0]               rx_status_pins,
   output logic [7:0]               tx_status_pins,
   // receive engine
   input  wire logic                rx_byte_valid,
   input  wire logic [7:0]          rx_byte,
   input  wire logic                rx_byte_last,
   input  wire logic                rx_frame_done,
   input  wire logic [7:0]          rx_frame_status,
   output logic                     rx_buf_ready,
   output logic                     free_list_perr,
   // transmit engine
   input  wire logic                tx_attention,
   input  wire logic [7:0]          tx_status,
   input  wire logic                tx_fetch,
   input  wire logic [TX_AW-1:0]    tx_fetch_addr,
   output alc_pkg::alc_word_t       tx_fetch_word,
   output logic                     tx_parity_err,
   input  wire logic [7:0]          collision_test,
   // long-term controls and indirect registers
   output logic [7:0]               link_ctrl,
   output logic [47:0]              station_address,
   output logic [15:0]              reflectometry_count
);
   localparam int CNT_W = RX_AW - BASE_W;
   if (CNT_W < 1 || BASE_W != 8 || TX_AW < 1 || TX_AW > 16) begin : g_bad_width
      $error("receive needs an 8-bit base and counter, transmit 1 to 16 bits");
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset release and pin synchronisers
   logic [1:0]         rst_sync_q;
   logic               rst_n;
   alc_pkg::alc_pins_t pins_m_q, pins_q;
   logic [1:0]         pclk_m_q;
   logic               pclk_q, pclk_old_q;
   logic               init_m_q, init_q;
   logic               pstb;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) rst_sync_q <= 2'h0;
      else       rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   // port clock sampled as a level; its falling edge (mid-cycle) is the action point
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pins_m_q   <= '{sel_n: 1'b1, ctrl: 4'h0, data: 8'h00, parity: 1'b0};
         pins_q     <= '{sel_n: 1'b1, ctrl: 4'h0, data: 8'h00, parity: 1'b0};
         pclk_m_q   <= 2'h3;  // idle high, so release shows no false edge
         pclk_q     <= 1'b1;
         pclk_old_q <= 1'b1;
         init_m_q   <= 1'b1;
         init_q     <= 1'b1;
      end else begin
         pins_m_q   <= port_pins;
         pins_q     <= pins_m_q;
         pclk_m_q   <= {pclk_m_q[0], port_clk};
         pclk_q     <= pclk_m_q[1];
         pclk_old_q <= pclk_q;
         init_m_q   <= port_init;
         init_q     <= init_m_q;
      end
   end
   assign pstb = pclk_old_q && !pclk_q;

   ////////////////////////////////////////////////////////////////////////////
   // command decode
   logic       act;
   logic [3:0] cmd;
   logic [7:0] din, index_q;
   logic       c_rdbuf, c_rdstat, c_rdused, c_copy, c_clratt;
   logic       c_set, c_clr, c_base, c_free, c_flush, c_idx, c_rdreg, c_wtreg;
   logic       guard_ok;

   assign act      = pstb && !pins_q.sel_n && !init_q;
   assign cmd      = pins_q.ctrl;
   assign din      = pins_q.data;
   assign c_rdbuf  = act && cmd == `ALC_CMD_READ_RX_BUFFER;
   assign c_rdstat = act && cmd == `ALC_CMD_READ_RX_STATUS;
   assign c_rdused = act && cmd == `ALC_CMD_READ_FILLED_LIST;
   assign c_copy   = act && cmd == `ALC_CMD_COPY_RX_TO_TX;
   assign c_clratt = act && cmd == `ALC_CMD_CLEAR_RX_ATTENTION;
   assign c_set    = act && cmd == `ALC_CMD_SET_CONTROL_BITS;
   assign c_clr    = act && cmd == `ALC_CMD_CLEAR_CONTROL_BITS;
   assign c_base   = act && cmd == `ALC_CMD_LOAD_RX_READ_BASE;
   assign c_free   = act && cmd == `ALC_CMD_PUSH_FREE_LIST;
   assign c_flush  = act && cmd == `ALC_CMD_FLUSH_RX_LISTS;
   assign c_idx    = act && cmd == `ALC_CMD_LOAD_INDEX;
   assign c_rdreg  = act && cmd == `ALC_CMD_INDEXED_READ;
   assign c_wtreg  = act && cmd == `ALC_CMD_INDEXED_WRITE;
   assign guard_ok = !link_ctrl[`ALC_CTRL_ENABLE_LINK_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // receive lists: free bases (with parity), filled bases, frame status
   logic [8:0] free_head;
   logic [7:0] used_head, stat_head;
   logic       free_empty, used_empty, stat_empty;
   logic       frame_end, list_flush;
   assign frame_end  = rx_frame_done && !free_empty;
   assign list_flush = c_flush || init_q;

   alc_fifo #(.W(9), .D(LIST_D)) u_free (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .flush     (list_flush),
      .push      (c_free),
      .push_data ({pins_q.parity, din}),
      .pop       (frame_end),
      .head      (free_head),
      .empty     (free_empty),
      .full      ()
   );

   alc_fifo #(.W(8), .D(LIST_D)) u_used (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .flush     (list_flush),
      .push      (frame_end),
      .push_data (free_head[7:0]),
      .pop       (c_rdused),
      .head      (used_head),
      .empty     (used_empty),
      .full      ()
   );

   alc_fifo #(.W(8), .D(LIST_D)) u_stat (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .flush     (list_flush),
      .push      (frame_end),
      .push_data (rx_frame_status),
      .pop       (c_clratt),
      .head      (stat_head),
      .empty     (stat_empty),
      .full      ()
   );

   ////////////////////////////////////////////////////////////////////////////
   // receive memory: parity, data and a last-byte mark per location
   logic [9:0]        rx_mem [2**RX_AW];
   logic [BASE_W-1:0] rd_base_q;
   logic [CNT_W-1:0]  rd_cnt_q, wr_cnt_q;
   logic [RX_AW-1:0]  rd_addr, wr_addr;
   logic [9:0]        rd_word;
   logic              eng_wr, port_wr;

   assign rd_addr = {rd_base_q, rd_cnt_q};
   assign wr_addr = {free_head[7:0], wr_cnt_q};
   assign rd_word = rx_mem[rd_addr];
   assign eng_wr  = rx_byte_valid && !free_empty;
   assign port_wr = c_wtreg && guard_ok && index_q == `ALC_IDX_RECEIVE_MEMORY_WRITE;

   // engine bytes get odd parity; port writes keep the parity it sent
   always_ff @(posedge clk_sys) begin
      if (eng_wr) begin
         rx_mem[wr_addr] <= {rx_byte_last, ~^rx_byte, rx_byte};
      end else if (port_wr) begin
         rx_mem[wr_addr] <= {1'b0, pins_q.parity, din};
      end
   end

   // read base and counters; base load zeroes the low-order read counter
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_base_q <= '0;
         rd_cnt_q  <= '0;
         wr_cnt_q  <= '0;
      end else begin
         if (c_base) begin
            rd_base_q <= din;
            rd_cnt_q  <= '0;
         end else if (c_rdbuf || c_copy) begin
            rd_cnt_q  <= rd_cnt_q + CNT_W'(1);
         end
         if (frame_end || list_flush)   wr_cnt_q <= '0;
         else if (eng_wr || port_wr)    wr_cnt_q <= wr_cnt_q + CNT_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit buffer: copy target, readback and engine fetch with parity check
   alc_pkg::alc_word_t tx_mem [2**TX_AW];
   logic [TX_AW-1:0]   tx_addr_q;
   alc_pkg::alc_word_t fetch_w;

   always_ff @(posedge clk_sys) begin
      if (c_copy) tx_mem[tx_addr_q] <= rd_word[8:0];
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)      tx_addr_q <= '0;
      else if (c_copy) tx_addr_q <= tx_addr_q + TX_AW'(1);
   end

   // parity kept as supplied, checked only when the engine fetches
   assign fetch_w = tx_mem[tx_fetch_addr];
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_fetch_word <= '0;
         tx_parity_err <= 1'b0;
      end else begin
         if (tx_fetch) tx_fetch_word <= fetch_w;
         tx_parity_err <= tx_fetch && !(^{fetch_w.parity, fetch_w.data});
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // indirect registers and long-term controls
   logic [7:0]  reg_rd;
   logic [47:0] sta_q;
   logic [15:0] tdr_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) index_q <= `ALC_BYTE_RESET;
      else if (c_idx) index_q <= din;
   end

   // set wins over clear only in the sense that each command touches its own ones
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)       link_ctrl <= `ALC_CTRL_RESET;
      else if (init_q)  link_ctrl <= `ALC_CTRL_RESET;
      else if (c_set)   link_ctrl <= link_ctrl | din;
      else if (c_clr)   link_ctrl <= link_ctrl & ~din;
   end

   // writable indices; read-only or unmapped targets ignore the write
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sta_q <= '0;
         tdr_q <= '0;
      end else if (c_wtreg) begin
         if (index_q <= `ALC_IDX_STATION_ADDRESS_BYTE5 && guard_ok)
            sta_q[index_q[2:0]*8 +: 8] <= din;
         if (index_q == `ALC_IDX_REFLECTOMETRY_COUNT_LOW)  tdr_q[7:0]  <= din;
         if (index_q == `ALC_IDX_REFLECTOMETRY_COUNT_HIGH) tdr_q[15:8] <= din;
      end
   end
   assign station_address     = sta_q;
   assign reflectometry_count = tdr_q;

   // readable indices; write-only and unmapped read as zero
   always_comb begin
      reg_rd = 8'h00;
      if (index_q >= `ALC_IDX_FACTORY_ADDRESS_ROM0 && index_q <= `ALC_IDX_FACTORY_ADDRESS_ROM5)
         reg_rd = ROM_VALUE[index_q[2:0]*8 +: 8];
      else if (index_q == `ALC_IDX_TRANSMIT_BUFFER_READBACK)
         reg_rd = tx_mem[tx_addr_q].data;
      else if (index_q == `ALC_IDX_COLLISION_TEST_RESULT)
         reg_rd = collision_test;
   end

   ////////////////////////////////////////////////////////////////////////////
   // data lines: one answer per port cycle, held until the next action point
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         data_out        <= 8'h00;
         data_oe         <= 1'b0;
         rx_data_parity  <= 1'b0;
         frame_last_byte <= 1'b0;
      end else if (pstb) begin
         data_oe         <= c_rdbuf || c_rdstat || c_rdused || c_rdreg;
         frame_last_byte <= c_rdbuf && rd_word[9];
         rx_data_parity  <= c_rdbuf ? rd_word[8] : 1'b0;
         if (c_rdbuf)       data_out <= rd_word[7:0];
         else if (c_rdstat) data_out <= stat_empty ? 8'h00 : stat_head;
         else if (c_rdused) data_out <= used_empty ? 8'h00 : used_head;
         else if (c_rdreg)  data_out <= reg_rd;
         else               data_out <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // attention, gated status pins and list health
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_attention   <= 1'b0;
         rx_status_pins <= 8'h00;
         tx_status_pins <= 8'h00;
         rx_buf_ready   <= 1'b0;
         free_list_perr <= 1'b0;
      end else begin
         rx_attention   <= !stat_empty && !c_clratt;
         rx_status_pins <= (stat_empty || c_clratt) ? 8'h00 : stat_head;
         tx_status_pins <= tx_attention ? tx_status : 8'h00;
         rx_buf_ready   <= !free_empty;
         // parity of the base in use; the flush clears it only if no bad base is at the head in that cycle
         if (!free_empty && !(^free_head)) free_list_perr <= 1'b1;
         else if (list_flush)              free_list_perr <= 1'b0;
      end
   end
endmodule

//--- inc/alc_map.svh
// constants for the adapter link command port: command codes, indices, bits, reset values
`ifndef ALC_MAP_SVH
`define ALC_MAP_SVH

// link-control command codes
`define ALC_CMD_READ_RX_BUFFER      4'h2
`define ALC_CMD_READ_RX_STATUS      4'hE
`define ALC_CMD_READ_FILLED_LIST    4'hB
`define ALC_CMD_COPY_RX_TO_TX       4'h3
`define ALC_CMD_CLEAR_RX_ATTENTION  4'h7
`define ALC_CMD_SET_CONTROL_BITS    4'h8
`define ALC_CMD_CLEAR_CONTROL_BITS  4'h9
`define ALC_CMD_LOAD_RX_READ_BASE   4'h5
`define ALC_CMD_PUSH_FREE_LIST      4'h4
`define ALC_CMD_FLUSH_RX_LISTS      4'h1
`define ALC_CMD_LOAD_INDEX          4'hA
`define ALC_CMD_INDEXED_READ        4'h0
`define ALC_CMD_INDEXED_WRITE       4'hF

// indirect register indices
`define ALC_IDX_STATION_ADDRESS_BYTE0    8'h00
`define ALC_IDX_STATION_ADDRESS_BYTE5    8'h05
`define ALC_IDX_FACTORY_ADDRESS_ROM0     8'h08
`define ALC_IDX_FACTORY_ADDRESS_ROM5     8'h0D
`define ALC_IDX_TRANSMIT_BUFFER_READBACK 8'h10
`define ALC_IDX_RECEIVE_MEMORY_WRITE     8'h11
`define ALC_IDX_REFLECTOMETRY_COUNT_LOW  8'h12
`define ALC_IDX_REFLECTOMETRY_COUNT_HIGH 8'h13
`define ALC_IDX_COLLISION_TEST_RESULT    8'h14

// control bit positions and reset values
`define ALC_CTRL_ENABLE_LINK_BIT 0
`define ALC_CTRL_RESET           8'h00
`define ALC_BYTE_RESET           8'h00

`endif

//--- inc/alc_pkg.sv
// types shared by the adapter link command port
package alc_pkg;

   // port-side pins sampled together on one port clock edge
   typedef struct packed {
      logic       sel_n;
      logic [3:0] ctrl;
      logic [7:0] data;
      logic       parity;
   } alc_pins_t;

   // one receive or transmit memory word: parity above data
   typedef struct packed {
      logic       parity;
      logic [7:0] data;
   } alc_word_t;

endpackage

//--- bench/alc_port_model.sv
// port-side model: one request becomes one selected port clock cycle
`timescale 1ns/10ps
module alc_port_model (
   // system side
   input  wire logic          clk_sys,
   input  wire logic          req,
   input  wire logic [3:0]    cmd,
   input  wire logic [7:0]    arg,
   output logic               ack,
   // port pins
   output logic               port_clk,
   output alc_pkg::alc_pins_t port_pins
);
   logic [5:0] cnt_q = 6'h00;

   ////////////////////////////////////////
   // 33 cycle port period; the clock idles high between commands
   always @(posedge clk_sys) begin
      ack <= 1'b0;
      cnt_q <= (cnt_q == 6'h20 || (cnt_q == 6'h00 && !req)) ? 6'h00 : cnt_q + 6'h01;
      if (cnt_q == 6'h01) begin
         port_pins <= '{1'b0, cmd, arg, ~^arg};
      end
      if (cnt_q == 6'h08) begin
         port_clk <= 1'b0;
      end
      if (cnt_q == 6'h14) begin
         ack <= 1'b1;
      end
      // release: select pulled high, lines no longer hold the last value
      if (cnt_q == 6'h18) begin
         port_clk <= 1'b1;
         port_pins <= '{1'b1, ~port_pins.ctrl, ~port_pins.data, ~port_pins.parity};
      end
   end

   // idle state before the first command
   initial begin
      port_clk = 1'b1;
      ack = 1'b0;
      port_pins = '{1'b1, 4'h0, 8'hA5, 1'b0};
   end
endmodule

//--- bench/alc_cmd_port_checker.sv
// assertions on the command port top, bound at the foot
`timescale 1ns/10ps
module alc_cmd_port_checker (
   // clock and reset
   input wire logic               clk_sys,
   input wire logic               rstn,
   // watched ports
   input wire logic               port_init,
   input wire alc_pkg::alc_pins_t port_pins,
   input wire logic               data_oe,
   input wire logic               frame_last_byte,
   input wire logic               rx_attention,
   input wire logic [7:0]         rx_status_pins,
   input wire logic               tx_attention,
   input wire logic [7:0]         tx_status,
   input wire logic [7:0]         tx_status_pins,
   input wire logic               rx_frame_done,
   input wire logic               tx_fetch,
   input wire alc_pkg::alc_word_t tx_fetch_word,
   input wire logic               tx_parity_err,
   input wire logic [7:0]         link_ctrl
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   // a fetch and the cycle that answers it
   sequence fetch_s;
      tx_fetch ##1 1'b1;
   endsequence

   // answers, markers, status gating, attention, initialize and fetch parity
   chk_oe_selected: assert property ($rose(data_oe) |-> !$past(port_pins.sel_n, 4))
      else $error("answer started without select");
   chk_last_with_data: assert property (frame_last_byte |-> data_oe)
      else $error("frame end marker without data");
   chk_rx_gated: assert property (!rx_attention |-> rx_status_pins == 8'h00)
      else $error("receive status pins open without attention");
   chk_tx_gated: assert property (!tx_attention && !$past(tx_attention) |-> tx_status_pins == 8'h00)
      else $error("transmit status pins open without attention");
   chk_tx_mirror: assert property (tx_attention && $past(tx_attention) && $stable(tx_status)
      |-> tx_status_pins == tx_status)
      else $error("transmit status pins differ from status");
   chk_attn_follows: assert property (rx_frame_done |-> ##[1:3] rx_attention)
      else $error("attention missing after frame");
   chk_init_clears: assert property (port_init [*8] |-> link_ctrl == 8'h00)
      else $error("controls not cleared by initialize");
   chk_perr_cause: assert property (tx_parity_err |-> $past(tx_fetch))
      else $error("parity error without fetch");
   chk_fetch_parity: assert property (fetch_s |-> tx_parity_err == !(^tx_fetch_word))
      else $error("parity error flag wrong for fetched word");
endmodule

////////////////////////////////////////
bind alc_cmd_port alc_cmd_port_checker u_chk (.clk_sys, .rstn, .port_init, .port_pins,
   .data_oe, .frame_last_byte, .rx_attention, .rx_status_pins, .tx_attention, .tx_status,
   .tx_status_pins, .rx_frame_done, .tx_fetch, .tx_fetch_word, .tx_parity_err, .link_ctrl);

//--- bench/alc_cmd_port_tb_top.sv
// self-checking bench for the adapter link command port
`timescale 1ns/10ps
`include "alc_map.svh"
module alc_cmd_port_tb_top;
   localparam logic [47:0] ROM = 48'h3C5A96E1F00F; // arbitrary factory address
   localparam logic [7:0] NORD[5] = '{8'h00, 8'h06, 8'h0F, 8'h11, 8'hFF};
   logic clk_sys = 1'b0, rstn = 1'b0, port_init = 1'b1, req = 1'b0;
   logic [3:0] cmd = 4'h0;
   logic [7:0] arg = 8'h00, rx_byte = 8'h00, rx_frame_status = 8'h00;
   logic [7:0] tx_status = 8'h00, collision_test = 8'h00;
   logic rx_byte_valid = 1'b0, rx_byte_last = 1'b0, rx_frame_done = 1'b0;
   logic tx_attention = 1'b0, tx_fetch = 1'b0;
   logic [10:0] tx_fetch_addr = 11'h000;
   logic ack, port_clk, data_oe, rx_data_parity, frame_last_byte, rx_attention;
   logic rx_buf_ready, free_list_perr, tx_parity_err;
   logic [7:0] data_out, rx_status_pins, tx_status_pins, link_ctrl, r;
   logic [7:0] fb[2][3], st[2], fr[2];
   logic [47:0] station_address, w;
   logic [15:0] reflectometry_count;
   logic [19:0] exp_q[$], mon_e;
   alc_pkg::alc_pins_t port_pins;
   alc_pkg::alc_word_t tx_fetch_word;
   int num_errors = 0, checked = 0;

   always #2.5 clk_sys = ~clk_sys;

   alc_port_model u_port (.clk_sys, .req, .cmd, .arg, .ack, .port_clk, .port_pins);
   alc_cmd_port #(.ROM_VALUE(ROM)) u_dut (.clk_sys, .rstn, .port_clk, .port_init, .port_pins,
      .data_out, .data_oe, .rx_data_parity, .frame_last_byte, .rx_attention, .rx_status_pins,
      .tx_status_pins, .rx_byte_valid, .rx_byte, .rx_byte_last, .rx_frame_done,
      .rx_frame_status, .rx_buf_ready, .free_list_perr, .tx_attention, .tx_status, .tx_fetch,
      .tx_fetch_addr, .tx_fetch_word, .tx_parity_err, .collision_test, .link_ctrl,
      .station_address, .reflectometry_count);

   ////////////////////////////////////////
   task automatic check_val(input string n, input logic [47:0] e, input logic [47:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // request held until the model acknowledges
   task automatic send(input logic [3:0] c, input logic [7:0] a);
      @(posedge clk_sys);
      #1 req = 1'b1;
      cmd = c;
      arg = a;
      do @(posedge clk_sys); while (ack !== 1'b1);
      #1 req = 1'b0;
   endtask
   task automatic rd(input logic [3:0] c, input logic [9:0] m, input logic [9:0] v);
      exp_q.push_back({m, v & m});
      send(c, 8'h00);
   endtask
   task automatic reg_rd(input logic [7:0] i, input logic [7:0] v);
      send(`ALC_CMD_LOAD_INDEX, i);
      rd(`ALC_CMD_INDEXED_READ, 10'h0FF, {2'b00, v});
   endtask
   task automatic reg_wr(input logic [7:0] i, input logic [7:0] v);
      send(`ALC_CMD_LOAD_INDEX, i);
      send(`ALC_CMD_INDEXED_WRITE, v);
   endtask
   // receive engine writes n bytes, then accepts the frame
   task automatic rx_frame(input int f, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys);
         #1 rx_byte_valid = 1'b1;
         rx_byte = fb[f][i];
         rx_byte_last = (i == n - 1);
         @(posedge clk_sys);
         #1 rx_byte_valid = 1'b0;
      end
      rx_frame_status = st[f];
      rx_frame_done = 1'b1;
      @(posedge clk_sys);
      #1 rx_frame_done = 1'b0;
   endtask
   task automatic complete_run;
      check_val("pending answers", 48'h0, 48'(exp_q.size()));
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   ////////////////////////////////////////
   // answers compared in the cycle the model raises ack
   always @(posedge clk_sys) begin
      if (ack === 1'b1 && data_oe === 1'b1) begin
         mon_e = (exp_q.size() != 0) ? exp_q.pop_front() : 20'hFFC00;
         check_val("answer", mon_e[9:0],
            {frame_last_byte, rx_data_parity, data_out} & mon_e[19:10]);
      end
   end
   // a hang ends the run as a failure
   initial begin
      repeat (30000) @(posedge clk_sys);
      num_errors++;
      complete_run;
   end
   // main sequence
   initial begin
      void'($urandom(3));
      foreach (fb[f, i]) fb[f][i] = 8'($urandom());
      foreach (st[f]) st[f] = 8'($urandom());
      fr[0] = 8'($urandom());
      fr[1] = ~fr[0]; // distinct bases keep the two frames apart
      w = {16'($urandom()), 32'($urandom())};
      r = 8'($urandom()) | 8'h01;
      repeat (16) @(posedge clk_sys);
      #1 rstn = 1'b1;
      repeat (12) @(posedge clk_sys);
      // transmit status only once the design is out of reset, so the mirror holds
      #1 port_init = 1'b0;
      collision_test = 8'($urandom());
      tx_status = 8'($urandom());
      tx_attention = 1'b1;
      repeat (8) @(posedge clk_sys);
      for (int i = 0; i < 6; i++) reg_rd(8'h08 + 8'(i), ROM[8*i +: 8]);
      for (int i = 0; i < 6; i++) reg_wr(8'(i), w[8*i +: 8]);
      check_val("station", w, station_address);
      foreach (NORD[k]) reg_rd(NORD[k], 8'h00);
      reg_rd(`ALC_IDX_COLLISION_TEST_RESULT, collision_test);
      reg_wr(`ALC_IDX_REFLECTOMETRY_COUNT_LOW, w[7:0]);
      reg_wr(`ALC_IDX_REFLECTOMETRY_COUNT_HIGH, w[15:8]);
      check_val("reflectometry", 48'(w[15:0]), 48'(reflectometry_count));
      tx_attention = 1'b0;
      send(`ALC_CMD_SET_CONTROL_BITS, r);
      check_val("controls set", 48'(r), 48'(link_ctrl));
      reg_wr(`ALC_IDX_STATION_ADDRESS_BYTE0, ~w[7:0]);
      check_val("guarded", w, station_address);
      send(`ALC_CMD_CLEAR_CONTROL_BITS, 8'h00);
      check_val("controls kept", 48'(r), 48'(link_ctrl));
      send(`ALC_CMD_CLEAR_CONTROL_BITS, r);
      check_val("controls cleared", 48'h0, 48'(link_ctrl));
      send(`ALC_CMD_PUSH_FREE_LIST, fr[0]);
      send(`ALC_CMD_PUSH_FREE_LIST, fr[1]);
      rx_frame(0, 3);
      rx_frame(1, 1);
      repeat (4) @(posedge clk_sys);
      check_val("attention", 48'h1, 48'(rx_attention));
      check_val("status pins", 48'(st[0]), 48'(rx_status_pins));
      rd(`ALC_CMD_READ_RX_STATUS, 10'h0FF, {2'b00, st[0]});
      rd(`ALC_CMD_READ_FILLED_LIST, 10'h0FF, {2'b00, fr[0]});
      rd(`ALC_CMD_READ_FILLED_LIST, 10'h0FF, {2'b00, fr[1]});
      send(`ALC_CMD_LOAD_RX_READ_BASE, fr[0]);
      for (int i = 0; i < 3; i++) begin
         rd(`ALC_CMD_READ_RX_BUFFER, 10'h3FF, {i == 2, ~^fb[0][i], fb[0][i]});
      end
      send(`ALC_CMD_LOAD_RX_READ_BASE, fr[0]);
      send(`ALC_CMD_COPY_RX_TO_TX, 8'h00);
      rd(`ALC_CMD_READ_RX_BUFFER, 10'h3FF, {1'b0, ~^fb[0][1], fb[0][1]});
      @(posedge clk_sys);
      #1 tx_fetch = 1'b1;
      @(posedge clk_sys);
      #1 tx_fetch = 1'b0;
      check_val("tx word", 48'({~^fb[0][0], fb[0][0]}), 48'(tx_fetch_word));
      send(`ALC_CMD_CLEAR_RX_ATTENTION, 8'h00);
      rd(`ALC_CMD_READ_RX_STATUS, 10'h0FF, {2'b00, st[1]});
      send(`ALC_CMD_CLEAR_RX_ATTENTION, 8'h00);
      check_val("attention off", 48'h0, 48'(rx_attention));
      send(`ALC_CMD_PUSH_FREE_LIST, fr[1]);
      check_val("free ready", 48'h1, 48'(rx_buf_ready));
      check_val("list parity", 48'h0, 48'(free_list_perr));
      send(`ALC_CMD_FLUSH_RX_LISTS, 8'h00);
      check_val("flushed", 48'h0, 48'(rx_buf_ready));
      // initialize in mid-run must drop the controls again
      send(`ALC_CMD_SET_CONTROL_BITS, r);
      port_init = 1'b1;
      repeat (10) @(posedge clk_sys);
      #1 port_init = 1'b0;
      check_val("init controls", 48'h0, 48'(link_ctrl));
      complete_run;
   end
endmodule
